// ---- design/swg_pkg.sv ----
// Purpose: Shared constants and types for the software wait-state generator.
// Assumes: Word-addressed 16-bit data memory space, 16-bit external addresses.
// Notes: Register locations and reset values are fixed here and used by name.
`default_nettype none

package swg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register locations in data memory space
    localparam logic [15:0] ADDR_PD_WAIT = 16'h0028;
    localparam logic [15:0] ADDR_IO_WAIT = 16'h0029;
    localparam logic [15:0] ADDR_WAIT_CTL = 16'h002A;
    localparam logic [15:0] ADDR_WAIT_STAT = 16'h002B;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values: largest field codes with range bits clear, so 3 waits in the field variant and 7 in the single-value variant
    localparam logic [15:0] RST_PD_WAIT = 16'hFFFF;
    localparam logic [15:0] RST_IO_WAIT = 16'hFFFF;
    localparam logic [4:0] RST_WAIT_CTL = 5'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Control register fields
    localparam int CTL_RANGE_PROG = 0;
    localparam int CTL_RANGE_DATA = 1;
    localparam int CTL_RANGE_IO = 2;
    localparam int CTL_PART_SEL = 4;
    localparam int CTL_WIDTH = 5;

    // Address fields that pick a 2-bit field
    localparam int BLK16K_MSB = 15;
    localparam int BLK16K_LSB = 14;
    localparam int BLK8K_MSB = 15;
    localparam int BLK8K_LSB = 13;
    localparam int PAIR_MSB = 3;
    localparam int PAIR_LSB = 1;
    localparam logic [2:0] DATA_FIELD_BASE = 3'h4;

    // Single-value variant: 3-bit fields in the program/data register
    localparam int SV_PROG_LSB = 0;
    localparam int SV_DATA_LSB = 3;
    localparam int SV_IO_LSB = 6;

    localparam int WAIT_W = 3;
    localparam logic [WAIT_W-1:0] WAIT_ZERO = 3'h0;
    localparam logic [WAIT_W-1:0] WAIT_ONE = 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [1:0] {
        SPACE_PROG = 2'h0,
        SPACE_DATA = 2'h1,
        SPACE_IO = 2'h2
    } swg_space_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_WAIT = 2'b10
    } swg_state_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } swg_dm_req_type;

    typedef struct packed {
        logic valid;
        swg_space_type space;
        logic [15:0] addr;
    } swg_acc_req_type;

endpackage : swg_pkg

`default_nettype wire

// ---- design/swg_wait_counter.sv ----
// Purpose: Down counter that times the wait states of one external access.
// Assumes: Load and decrement never asserted together by the caller.
// Notes: Holds at zero; zero flag comes straight from the count register.
`default_nettype none

module swg_wait_counter
    import swg_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [swg_pkg::WAIT_W-1:0] load_val,
    input wire logic dec,
    output logic [swg_pkg::WAIT_W-1:0] count,
    output logic zero
);

    logic [WAIT_W-1:0] cnt_q;
    logic [WAIT_W-1:0] cnt_d;

    ////////////////////////////////////////////////////////////////////////////
    // Next count: load wins, decrement saturates at zero
    always_comb begin
        cnt_d = cnt_q;
        if (load) begin
            cnt_d = load_val;
        end else if (dec && (cnt_q != WAIT_ZERO)) begin
            cnt_d = cnt_q - WAIT_ONE;
        end
    end

    // Count register
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= WAIT_ZERO;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    assign zero = (cnt_q == WAIT_ZERO);

endmodule // swg_wait_counter

`default_nettype wire

// ---- design/swg_top.sv ----
// Purpose: Software-programmable wait-state generator for off-chip accesses.
// Assumes: Register port and access requests come from logic on CLK.
// Notes: SINGLE_VALUE selects the variant with one 3-bit count per space.
`default_nettype none

// What this block does
// RULE1 - The program/data wait register holds eight 2-bit fields, one per 16K-word block.
// RULE2 - With partition select clear, each I/O wait field covers one pair of port addresses.
// RULE3 - With partition select set, I/O space is eight 8K-word blocks with one field each.
// RULE4 - The 5-bit control register sets the wait range of the fields and the I/O mapping.
// RULE5 - In the single-value variant each space takes one 3-bit count of 0 to 7 waits.
// RULE6 - The wait registers are read and written as locations in data memory space.
// RULE7 - Each external access is stretched by the wait states of its selected field.
module swg_top
    import swg_pkg::*;
#(
    parameter bit SINGLE_VALUE = 1'b0
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire swg_pkg::swg_dm_req_type DM_REQ,
    output logic [15:0] DM_RDATA,
    output logic DM_RVALID,
    input wire swg_pkg::swg_acc_req_type ACC_REQ,
    output logic ACC_BUSY,
    output logic ACC_DONE,
    output logic [swg_pkg::WAIT_W-1:0] ACC_WAITS
);

    ////////////////////////////////////////////////////////////////////////////
    // Functions

    // Pick a 2-bit field out of a 16-bit wait register
    function automatic logic [1:0] field2(input logic [15:0] r, input logic [2:0] idx);
        field2 = r[{idx, 1'b0} +: 2];
    endfunction

    // Map a 2-bit code to a wait count; the wide range trades step for reach
    function automatic logic [WAIT_W-1:0] scale(input logic [1:0] code, input logic wide);
        logic [WAIT_W-1:0] w;
        w = {1'b0, code};
        if (wide) begin
            case (code)
                2'h2: w = 3'h3;
                2'h3: w = 3'h7;
                default: w = {1'b0, code};
            endcase
        end
        scale = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    logic [15:0] pd_wait_q;
    logic [15:0] pd_wait_d;
    logic [15:0] io_wait_q;
    logic [15:0] io_wait_d;
    logic [CTL_WIDTH-1:0] wait_ctl_q;
    logic [CTL_WIDTH-1:0] wait_ctl_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic hit;

    // Access state, declared here because the status location reads it
    swg_state_type state_q;
    swg_state_type state_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;
    logic [WAIT_W-1:0] waits_q;
    logic [WAIT_W-1:0] waits_d;
    logic [WAIT_W-1:0] remain;
    logic cnt_zero;
    logic cnt_load;
    logic cnt_dec;

    // RULE6 data memory decode
    always_comb begin
        pd_wait_d = pd_wait_q;
        io_wait_d = io_wait_q;
        wait_ctl_d = wait_ctl_q;
        rdata_d = 16'h0000;
        hit = 1'b1;
        // Reads see the old value when write and read coincide
        case (DM_REQ.addr)
            ADDR_PD_WAIT: rdata_d = pd_wait_q;
            ADDR_IO_WAIT: rdata_d = io_wait_q;
            ADDR_WAIT_CTL: rdata_d = {11'h000, wait_ctl_q};
            ADDR_WAIT_STAT: rdata_d = {10'h000, remain, busy_q, state_q};
            default: hit = 1'b0;
        endcase
        if (DM_REQ.wr) begin
            case (DM_REQ.addr)
                ADDR_PD_WAIT: pd_wait_d = DM_REQ.wdata;
                ADDR_IO_WAIT: io_wait_d = DM_REQ.wdata;
                ADDR_WAIT_CTL: wait_ctl_d = DM_REQ.wdata[CTL_WIDTH-1:0];
                default: pd_wait_d = pd_wait_q;
            endcase
        end
        // Unmapped locations read as zero and still answer
        rvalid_d = DM_REQ.rd;
        if (!DM_REQ.rd || !hit) begin
            rdata_d = 16'h0000;
        end
    end

    // Register file storage
    always_ff @(posedge CLK) begin
        if (RST) begin
            pd_wait_q <= RST_PD_WAIT;
            io_wait_q <= RST_IO_WAIT;
            wait_ctl_q <= RST_WAIT_CTL;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
        end else begin
            pd_wait_q <= pd_wait_d;
            io_wait_q <= io_wait_d;
            wait_ctl_q <= wait_ctl_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wait-state lookup for the incoming access

    logic [2:0] pd_idx;
    logic [2:0] io_idx;
    logic [WAIT_W-1:0] lookup;

    always_comb begin
        pd_idx = {1'b0, ACC_REQ.addr[BLK16K_MSB:BLK16K_LSB]};
        // RULE2 port pair index
        io_idx = ACC_REQ.addr[PAIR_MSB:PAIR_LSB];
        lookup = WAIT_ZERO;
        if (SINGLE_VALUE) begin
            // RULE5 one count per space
            case (ACC_REQ.space)
                SPACE_PROG: lookup = pd_wait_q[SV_PROG_LSB +: WAIT_W];
                SPACE_DATA: lookup = pd_wait_q[SV_DATA_LSB +: WAIT_W];
                SPACE_IO: lookup = pd_wait_q[SV_IO_LSB +: WAIT_W];
                default: lookup = WAIT_ZERO;
            endcase
        end else begin
            // RULE1 data blocks after program
            if (ACC_REQ.space == SPACE_DATA) begin
                pd_idx = pd_idx + DATA_FIELD_BASE;
            end
            // RULE3 8K-word I/O blocks
            if (wait_ctl_q[CTL_PART_SEL]) begin
                io_idx = ACC_REQ.addr[BLK8K_MSB:BLK8K_LSB];
            end
            // RULE4 range per space
            case (ACC_REQ.space)
                SPACE_PROG: lookup = scale(field2(pd_wait_q, pd_idx),
                                           wait_ctl_q[CTL_RANGE_PROG]);
                SPACE_DATA: lookup = scale(field2(pd_wait_q, pd_idx),
                                           wait_ctl_q[CTL_RANGE_DATA]);
                SPACE_IO: lookup = scale(field2(io_wait_q, io_idx),
                                         wait_ctl_q[CTL_RANGE_IO]);
                default: lookup = WAIT_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access sequencer

    // RULE7 stretch the bus cycle
    always_comb begin
        state_d = state_q;
        busy_d = busy_q;
        done_d = 1'b0;
        waits_d = waits_q;
        cnt_load = 1'b0;
        cnt_dec = 1'b0;
        case (state_q)
            ST_IDLE: begin
                // New requests are only taken here; others are ignored
                if (ACC_REQ.valid) begin
                    cnt_load = 1'b1;
                    waits_d = lookup;
                    busy_d = 1'b1;
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_zero) begin
                    done_d = 1'b1;
                    busy_d = 1'b0;
                    state_d = ST_IDLE;
                end else begin
                    cnt_dec = 1'b1;
                end
            end
            default: begin
                busy_d = 1'b0;
                state_d = ST_IDLE;
            end
        endcase
    end

    // Sequencer state
    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            waits_q <= WAIT_ZERO;
        end else begin
            state_q <= state_d;
            busy_q <= busy_d;
            done_q <= done_d;
            waits_q <= waits_d;
        end
    end

    // Counts the wait states of the access in flight
    swg_wait_counter u_cnt (
        .clk(CLK),
        .rst(RST),
        .load(cnt_load),
        .load_val(lookup),
        .dec(cnt_dec),
        .count(remain),
        .zero(cnt_zero)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops
    assign DM_RDATA = rdata_q;
    assign DM_RVALID = rvalid_q;
    assign ACC_BUSY = busy_q;
    assign ACC_DONE = done_q;
    assign ACC_WAITS = waits_q;

endmodule // swg_top

`default_nettype wire

// ---- tb/swg_monitor.sv ----
// Purpose: Port checker for the wait-state generator top.
// Assumes: One clock domain, synchronous active-high reset.
// Notes: Busy length is counted in helper logic, not unrolled.
`default_nettype none
module swg_monitor
    import swg_pkg::*;
#(
    parameter bit SINGLE_VALUE = 1'b0
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire swg_pkg::swg_dm_req_type DM_REQ,
    input wire logic [15:0] DM_RDATA,
    input wire logic DM_RVALID,
    input wire swg_pkg::swg_acc_req_type ACC_REQ,
    input wire logic ACC_BUSY,
    input wire logic ACC_DONE,
    input wire logic [swg_pkg::WAIT_W-1:0] ACC_WAITS
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] busy_cnt_q, busy_cnt_d;
    ////////////////////////////////////////
    // Run length of busy, cleared on any idle cycle
    always_comb begin
        busy_cnt_d = ACC_BUSY ? busy_cnt_q + 4'h1 : 4'h0;
    end
    always_ff @(posedge CLK) begin
        busy_cnt_q <= RST ? 4'h0 : busy_cnt_d;
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    read_answer_a:
    assert property (DM_REQ.rd |=> DM_RVALID) else $error("read got no valid");
    valid_cause_a:
    assert property (DM_RVALID |-> $past(DM_REQ.rd)) else $error("valid without read");
    rdata_idle_a:
    assert property (!DM_RVALID |-> DM_RDATA == 16'h0000) else $error("stray read data");
    take_busy_a:
    assert property (ACC_REQ.valid && !ACC_BUSY |=> ACC_BUSY && !ACC_DONE)
        else $error("access not taken");
    busy_end_a:
    assert property ($fell(ACC_BUSY) |-> ACC_DONE) else $error("busy ended without done");
    done_alone_a:
    assert property (ACC_DONE |-> !ACC_BUSY ##1 !ACC_DONE) else $error("done too long");
    stretch_len_a:
    assert property (ACC_DONE |-> busy_cnt_q == {1'b0, ACC_WAITS} + 4'h1)
        else $error("stretch length wrong");
    waits_hold_a:
    assert property (ACC_BUSY && $past(ACC_BUSY) |-> $stable(ACC_WAITS))
        else $error("waits moved");
    range_code_a:
    assert property (!SINGLE_VALUE && ACC_DONE |-> ACC_WAITS inside {[3'h0:3'h3], 3'h7})
        else $error("wait count off range");
    cover property (ACC_DONE && ACC_WAITS == 3'h7);
    cover property (ACC_DONE && ACC_WAITS == 3'h0);
    cover property (DM_RVALID);
endmodule // swg_monitor
bind swg_top swg_monitor #(.SINGLE_VALUE(SINGLE_VALUE)) swg_monitor_i (.CLK(CLK), .RST(RST),
    .DM_REQ(DM_REQ), .DM_RDATA(DM_RDATA), .DM_RVALID(DM_RVALID), .ACC_REQ(ACC_REQ),
    .ACC_BUSY(ACC_BUSY), .ACC_DONE(ACC_DONE), .ACC_WAITS(ACC_WAITS));
`default_nettype wire

// ---- tb/swg_ext_mem.sv ----
// Purpose: External memory stand-in that times each stretched access.
// Assumes: Holds its data phase for as long as the block keeps busy high.
// Notes: Count holds through the done cycle, cleared at its end.
`default_nettype none
module swg_ext_mem (
    input wire logic clk,
    input wire logic rst,
    input wire logic busy,
    input wire logic done,
    output logic [3:0] stretch
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_q, cnt_d;
    ////////////////////////////////////////
    // cycles per access
    always_comb begin
        cnt_d = done ? 4'h0 : (busy ? cnt_q + 4'h1 : cnt_q);
    end
    always_ff @(posedge clk) begin
        cnt_q <= rst ? 4'h0 : cnt_d;
    end
    assign stretch = cnt_q;
endmodule // swg_ext_mem
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: Self-checking bench for the wait-state generator.
// Assumes: Both variants built side by side, sharing the register port.
// Notes: Register and access strobes last one cycle each.
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import swg_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    swg_dm_req_type dm = '0;
    // Index 0 is the two-bit field variant, index 1 the single-value variant
    swg_acc_req_type acc [2] = '{default: '0};
    wire [15:0] rdata [2];
    wire rvalid [2];
    wire busy [2];
    wire done [2];
    wire [2:0] waits [2];
    wire [3:0] stretch [2];
    int n_fail = 0;
    int samples_checked = 0;
    // Field codes loaded as 16'h1BE4, and the widened range map
    logic [2:0] fld [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h2, 3'h1, 3'h0};
    logic [2:0] emap [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
    always #4 CLK = ~CLK;
    // Register writes reach both variants; each has its own access port
    for (genvar v = 0; v < 2; v++) begin : g_var
        swg_top #(.SINGLE_VALUE(v == 1)) swg_top_i (.CLK(CLK), .RST(RST), .DM_REQ(dm),
            .DM_RDATA(rdata[v]), .DM_RVALID(rvalid[v]), .ACC_REQ(acc[v]), .ACC_BUSY(busy[v]),
            .ACC_DONE(done[v]), .ACC_WAITS(waits[v]));
        swg_ext_mem swg_ext_mem_i (.clk(CLK), .rst(RST), .busy(busy[v]), .done(done[v]),
            .stretch(stretch[v]));
    end
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge CLK) dm <= '{1'b1, 1'b0, a, d};
        @(posedge CLK) dm.wr <= 1'b0;
    endtask
    // Answer is looked at in the one cycle it stands
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge CLK) dm <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge CLK) dm.rd <= 1'b0;
        @(negedge CLK);
        chk("rvalid", {15'h0, rvalid[0]}, 16'h0001);
        chk("rdata", rdata[0], e);
        chk("rvalid single", {15'h0, rvalid[1]}, 16'h0001);
        chk("rdata single", rdata[1], e);
    endtask
    // Wait for done under a bound, then judge count and stretch
    task automatic run_acc(input int v, input swg_space_type s, input logic [15:0] a,
        input logic [2:0] e);
        int i;
        @(posedge CLK) acc[v] <= '{1'b1, s, a};
        @(posedge CLK) acc[v].valid <= 1'b0;
        for (i = 0; i < 20 && done[v] !== 1'b1; i++) @(negedge CLK);
        if (done[v] !== 1'b1) begin
            n_fail++;
            tally_and_finish();
        end else begin
            chk("waits", {13'h0, waits[v]}, {13'h0, e});
            chk("stretch", {12'h0, stretch[v]}, {13'h0, e} + 16'h1);
        end
    endtask
    task automatic regs_scn();
        rd(ADDR_PD_WAIT, RST_PD_WAIT);
        rd(ADDR_IO_WAIT, RST_IO_WAIT);
        rd(ADDR_WAIT_CTL, {11'h0, RST_WAIT_CTL});
        rd(16'h0030, 16'h0000);
        wr(ADDR_WAIT_STAT, 16'hFFFF);
        rd(ADDR_WAIT_STAT, 16'h0001);
        wr(ADDR_WAIT_CTL, 16'hFFFF);
        rd(ADDR_WAIT_CTL, 16'h001F);
    endtask
    task automatic blocks_scn();
        wr(ADDR_PD_WAIT, 16'h1BE4);
        wr(ADDR_IO_WAIT, 16'h1BE4);
        wr(ADDR_WAIT_CTL, 16'h0000);
        for (int b = 0; b < 4; b++) begin
            run_acc(0, SPACE_PROG, {b[1:0], 14'h0}, fld[b]);
            run_acc(0, SPACE_DATA, {b[1:0], 14'h3FFF}, fld[4+b]);
        end
    endtask
    // Port pairs first, then 8K blocks
    task automatic io_scn();
        for (int i = 0; i < 8; i++) begin
            run_acc(0, SPACE_IO, {12'h0, i[2:0], 1'b1}, fld[i]);
        end
        wr(ADDR_WAIT_CTL, 16'h0010);
        for (int i = 0; i < 8; i++) begin
            run_acc(0, SPACE_IO, {i[2:0], 13'h1}, fld[i]);
        end
    endtask
    task automatic range_scn();
        wr(ADDR_WAIT_CTL, 16'h0007);
        for (int b = 0; b < 4; b++) begin
            run_acc(0, SPACE_PROG, {b[1:0], 14'h0}, emap[fld[b]]);
            run_acc(0, SPACE_DATA, {b[1:0], 14'h0}, emap[fld[4+b]]);
            run_acc(0, SPACE_IO, {12'h0, b[2:0], 1'b0}, emap[fld[b]]);
        end
    endtask
    // Single-value variant: prog 5, data 2, io 7; range and partition bits must not matter
    task automatic single_scn();
        wr(ADDR_PD_WAIT, 16'h01D5);
        wr(ADDR_WAIT_CTL, 16'h0017);
        run_acc(1, SPACE_PROG, 16'hC000, 3'h5);
        run_acc(1, SPACE_DATA, 16'h4000, 3'h2);
        run_acc(1, SPACE_IO, 16'h0003, 3'h7);
        run_acc(1, SPACE_IO, 16'hE000, 3'h7);
    endtask
    initial begin
        repeat (4) @(posedge CLK);
        RST <= 1'b0;
        regs_scn();
        blocks_scn();
        io_scn();
        range_scn();
        single_scn();
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
